// [qdc_pkg.sv]
// Purpose: shared constants and types for the quad converter command block
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes: register map is local to this block
package qdc_pkg;
    localparam int NUM_CH = 4;
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 10;
    localparam int DATA_BITS = 12;
    localparam int CODE_LSB = 2;
    localparam logic [4:0] LAST_BIT = 5'h0F;

    localparam logic [1:0] OP_WRITE_HOLD = 2'h0;
    localparam logic [1:0] OP_WRITE_UPDATE = 2'h1;
    localparam logic [1:0] OP_WRITE_ALL = 2'h2;
    localparam logic [1:0] OP_POWER_DOWN = 2'h3;

    localparam logic [1:0] TERM_HIZ = 2'h0;
    localparam logic [1:0] TERM_PULL_2K5 = 2'h1;
    localparam logic [1:0] TERM_PULL_100K = 2'h2;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_CODE0 = 8'h10;
    localparam logic [7:0] ADDR_HOLD0 = 8'h20;
    localparam logic [7:0] ADDR_STRIDE = 8'h04;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int STAT_PD_BIT = 0;
    localparam int STAT_TERM_LSB = 1;
    localparam int STAT_SEEN_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;

    typedef logic [CODE_BITS-1:0] qdc_code_t;

    typedef struct packed {
        logic channelAddressHi;
        logic channelAddressLo;
        logic operationCodeHi;
        logic operationCodeLo;
        logic [DATA_BITS-1:0] dataCode;
    } qdc_frame_t;
endpackage

// [qdc_serial_rx.sv]
// Purpose: three-wire serial frame receiver, sampled on the system clock
// Assumes: serial clock at most a quarter of the system clock rate
// Notes: all pins pass two flip-flops before any logic reads them
`timescale 1ns/100ps
module qdc_serial_rx
    import qdc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic sclkPin,
    input wire logic frameSelectNPin,
    input wire logic dataInPin,
    input wire logic portEnable,
    output logic frameValid,
    output qdc_frame_t frameWord,
    output logic frameAbort,
    output logic frameBusy
);
    typedef enum logic [1:0] {SR_IDLE, SR_SHIFT, SR_DONE} qdc_rx_state_t;

    logic [2:0] sclkSync_ff;
    logic [1:0] selSync_ff;
    logic [1:0] dinSync_ff;
    qdc_rx_state_t state_ff;
    logic [4:0] bitCount_ff;
    logic [FRAME_BITS-2:0] shift_ff;
    logic sclkFall;
    logic selLow;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            // clock idles high; select reads low until the pin is really seen high
            sclkSync_ff <= 3'h7;
            selSync_ff <= 2'h0;
            dinSync_ff <= 2'h0;
        end
        else
        begin
            sclkSync_ff <= {sclkSync_ff[1:0], sclkPin};
            selSync_ff <= {selSync_ff[0], frameSelectNPin};
            dinSync_ff <= {dinSync_ff[0], dataInPin};
        end
    end

    assign sclkFall = sclkSync_ff[2] & ~sclkSync_ff[1];
    assign selLow = ~selSync_ff[1];

    // reset into done so a select line held low through reset never opens a frame
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= SR_DONE;
            bitCount_ff <= 5'h00;
            shift_ff <= '0;
            frameWord <= '0;
            frameValid <= 1'b0;
            frameAbort <= 1'b0;
        end
        else
        begin
            frameValid <= 1'b0;
            frameAbort <= 1'b0;
            case (state_ff)
                SR_IDLE:
                begin
                    bitCount_ff <= 5'h00;
                    if (selLow && portEnable)
                        state_ff <= SR_SHIFT;
                end
                SR_SHIFT:
                begin
                    if (!selLow)
                    begin
                        frameAbort <= 1'b1;
                        state_ff <= SR_IDLE;
                    end
                    else if (sclkFall)
                    begin
                        shift_ff <= {shift_ff[FRAME_BITS-3:0], dinSync_ff[1]};
                        bitCount_ff <= bitCount_ff + 5'h01;
                        if (bitCount_ff == LAST_BIT)
                        begin
                            frameWord <= {shift_ff, dinSync_ff[1]};
                            frameValid <= 1'b1;
                            state_ff <= SR_DONE;
                        end
                    end
                end
                SR_DONE:
                begin
                    // further clocks and data are dropped until select rises
                    if (!selLow)
                        state_ff <= SR_IDLE;
                end
                default:
                    state_ff <= SR_IDLE;
            endcase
        end
    end

    assign frameBusy = (state_ff == SR_SHIFT);

    a_frame_len: assert property (@(posedge clk_sys) disable iff (!resetn)
        frameValid |-> $past(bitCount_ff) == LAST_BIT && state_ff == SR_DONE)
        else $error("frame completed without sixteen edges");
    a_done_ignore: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_ff == SR_DONE && selLow |=> !frameValid && state_ff == SR_DONE)
        else $error("clock after sixteenth edge was not ignored");
endmodule

// [qdc_top.sv]
// Purpose: command decode and channel registers of a quad voltage-output converter
// Assumes: serial pins from an outside host, APB slave on clk_sys
// Notes: one wait state on every APB access; pslverr on unmapped addresses
`timescale 1ns/100ps
// Summary of operation
// - frame is two address bits, two operation bits, twelve data bits, msb first.
// - while select is low, one data bit shifts in per falling serial clock.
// - after sixteen edges further clocks are ignored until select rises again.
// - non power-down codes write one holding, write and update all, or write all.
// - the command executes on the sixteenth falling edge of a full frame.
// - select rising early discards the frame; only the abort count changes.
// - reset clears all four channel registers to zero.
// - outputs stay at the zero code until the first valid frame.
// - operation code 11 powers down all four channels regardless of address.
// - in power-down the address field selects high-z, 2.5k or 100k termination.
// - any power-down mode asserts shutdown to the analog circuitry.
// - power-down leaves every channel register unchanged.
// - a non power-down frame wakes the part; unwritten registers keep their values.
module qdc_top
    import qdc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclkPin,
    input wire logic frameSelectNPin,
    input wire logic dataInPin,
    output qdc_code_t [NUM_CH-1:0] chanCode,
    output logic shutdown,
    output logic [1:0] termSel
);
    logic [31:0] ctrl_ff;
    qdc_code_t [NUM_CH-1:0] hold_ff;
    logic anySeen_ff;
    logic [15:0] validCount_ff;
    logic [15:0] abortCount_ff;
    logic frameValid;
    logic frameAbort;
    logic frameBusy;
    qdc_frame_t frameWord;
    logic [1:0] frameAddr;
    logic [1:0] frameOp;
    qdc_code_t frameCode;
    logic apbAccess;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;

    qdc_serial_rx u_rx (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .sclkPin(sclkPin),
        .frameSelectNPin(frameSelectNPin),
        .dataInPin(dataInPin),
        .portEnable(ctrl_ff[CTRL_ENABLE_BIT]),
        .frameValid(frameValid),
        .frameWord(frameWord),
        .frameAbort(frameAbort),
        .frameBusy(frameBusy)
    );

    assign frameAddr = {frameWord.channelAddressHi, frameWord.channelAddressLo};
    assign frameOp = {frameWord.operationCodeHi, frameWord.operationCodeLo};
    // two lowest data bits are below the resolution and dropped
    assign frameCode = frameWord.dataCode[DATA_BITS-1:CODE_LSB];

    // holding registers; power-down frames leave them alone
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            hold_ff <= '0;
        else if (frameValid)
        begin
            case (frameOp)
                OP_WRITE_HOLD,
                OP_WRITE_UPDATE:
                    hold_ff[frameAddr] <= frameCode;
                OP_WRITE_ALL:
                    hold_ff <= {NUM_CH{frameCode}};
                default:
                    hold_ff <= hold_ff;
            endcase
        end
    end

    // output codes follow the holding registers only on a write-and-update or write-all command
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            chanCode <= '0;
        else if (frameValid)
        begin
            case (frameOp)
                OP_WRITE_UPDATE:
                begin
                    chanCode <= hold_ff;
                    chanCode[frameAddr] <= frameCode;
                end
                OP_WRITE_ALL:
                    chanCode <= {NUM_CH{frameCode}};
                default:
                    chanCode <= chanCode;
            endcase
        end
    end

    // power-down mode and termination
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            shutdown <= 1'b0;
            termSel <= TERM_HIZ;
        end
        else if (frameValid)
        begin
            if (frameOp == OP_POWER_DOWN)
            begin
                shutdown <= 1'b1;
                case (frameAddr)
                    2'h1: termSel <= TERM_PULL_2K5;
                    2'h2: termSel <= TERM_PULL_100K;
                    default: termSel <= TERM_HIZ;
                endcase
            end
            else
            begin
                shutdown <= 1'b0;
                termSel <= TERM_HIZ;
            end
        end
    end

    // the host is expected to go quiet in power-down; the receiver copes if it does not
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            anySeen_ff <= 1'b0;
            validCount_ff <= 16'h0000;
            abortCount_ff <= 16'h0000;
        end
        else
        begin
            if (frameValid)
            begin
                anySeen_ff <= 1'b1;
                validCount_ff <= validCount_ff + 16'h0001;
            end
            if (frameAbort)
                abortCount_ff <= abortCount_ff + 16'h0001;
        end
    end

    assign apbAccess = psel & penable & ~pready;

    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (paddr == ADDR_CTRL)
            nxt_prdata = ctrl_ff;
        else if (paddr == ADDR_STATUS)
        begin
            nxt_prdata[STAT_PD_BIT] = shutdown;
            nxt_prdata[STAT_TERM_LSB+1:STAT_TERM_LSB] = termSel;
            nxt_prdata[STAT_SEEN_BIT] = anySeen_ff;
            nxt_prdata[STAT_BUSY_BIT] = frameBusy;
        end
        else if (paddr == ADDR_COUNT)
            nxt_prdata = {abortCount_ff, validCount_ff};
        else
        begin
            nxt_pslverr = 1'b1;
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (paddr == ADDR_CODE0 + 8'(i) * ADDR_STRIDE)
                begin
                    nxt_prdata[CODE_BITS-1:0] = chanCode[i];
                    nxt_pslverr = 1'b0;
                end
                if (paddr == ADDR_HOLD0 + 8'(i) * ADDR_STRIDE)
                begin
                    nxt_prdata[CODE_BITS-1:0] = hold_ff[i];
                    nxt_pslverr = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apbAccess;
            pslverr <= apbAccess & nxt_pslverr;
            prdata <= (apbAccess && !pwrite && !nxt_pslverr) ? nxt_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            ctrl_ff <= CTRL_RESET;
        else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
            ctrl_ff <= {31'h0000_0000, pwdata[CTRL_ENABLE_BIT]};
    end

    sequence s_frame(logic [1:0] op);
        frameValid && frameOp == op;
    endsequence

    sequence s_pd_frame;
        s_frame(OP_POWER_DOWN);
    endsequence

    a_hold_only: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_frame(OP_WRITE_HOLD) |=> hold_ff[$past(frameAddr)] == $past(frameCode) && $stable(chanCode))
        else $error("hold write changed outputs or missed register");
    a_update_all: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_frame(OP_WRITE_UPDATE) |=> chanCode == hold_ff && hold_ff[$past(frameAddr)] == $past(frameCode))
        else $error("write and update left outputs behind");
    a_write_all: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_frame(OP_WRITE_ALL) |=> chanCode == {NUM_CH{$past(frameWord.dataCode[DATA_BITS-1:CODE_LSB])}})
        else $error("broadcast write wrong code");
    a_pd_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_pd_frame |=> shutdown && $stable(hold_ff) && $stable(chanCode))
        else $error("power-down touched channel registers");
    a_pd_term: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_pd_frame ##1 1'b1 |-> termSel == (($past(frameAddr) == 2'h1) ? TERM_PULL_2K5 :
            ($past(frameAddr) == 2'h2) ? TERM_PULL_100K : TERM_HIZ))
        else $error("termination select mismatch");
    a_wake_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        frameValid && frameOp != OP_POWER_DOWN |=> !shutdown)
        else $error("command frame did not end power-down");
    a_zero_start: assert property (@(posedge clk_sys) disable iff (!resetn)
        !anySeen_ff |-> chanCode == '0)
        else $error("output code nonzero before first frame");
    a_abort_still: assert property (@(posedge clk_sys) disable iff (!resetn)
        frameAbort |-> !frameValid ##1 ($stable(chanCode) && $stable(shutdown) && $stable(hold_ff)))
        else $error("aborted frame changed state");
    a_pd_only_frame: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(shutdown) |-> $past(frameValid) && $past(frameOp) == OP_POWER_DOWN)
        else $error("shutdown rose without power-down frame");
endmodule

// [qdc_serial_host.sv]
// Purpose: serial host model framing commands for the converter block
// Assumes: link clock half period of four system cycles, 64 ns period
// Notes: link clock stands still high outside frames; released data shows its inverse
`timescale 1ns/100ps
module qdc_serial_host
(
    input wire logic clk_sys,
    output logic sclk,
    output logic selN,
    output logic din
);
    initial
    begin
        sclk = 1'b1;
        selN = 1'b1;
        din = 1'b0;
    end

    task automatic halfBit();
        repeat (4) @(posedge clk_sys);
    endtask

    // edges past sixteen carry the inverse of the last bit, so ignoring them shows
    task automatic sendFrame(input logic [15:0] w, input int edges);
        int i;
        // a parked select must rise before a new frame may open
        if (selN == 1'b0)
        begin
            selN <= 1'b1;
            halfBit();
        end
        selN <= 1'b0;
        halfBit();
        for (i = 0; i < edges; i++)
        begin
            din <= (i < 16) ? w[15-i] : ~w[0];
            halfBit();
            sclk <= 1'b0;
            halfBit();
            sclk <= 1'b1;
        end
        halfBit();
        selN <= 1'b1;
        din <= ~din;
        halfBit();
    endtask

    // power-down idle: select and data low, clock stopped high
    task automatic parkLow();
        selN <= 1'b0;
        din <= 1'b0;
        halfBit();
        halfBit();
    endtask
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the quad converter command block
// Assumes: APB answers within fifty cycles
// Notes: integer model of codes, power-down, termination and frame counts gives each expectation except pready, ctrl and slverr
`timescale 1ns/100ps
module testbench import qdc_pkg::*;;
    logic clk_sys;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sclk;
    logic selN;
    logic din;
    qdc_code_t [NUM_CH-1:0] chanCode;
    logic shutdown;
    logic [1:0] termSel;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    int holdM[NUM_CH];
    int outM[NUM_CH];
    int pdM = 0;
    int termM = 0;
    int enM = 1;
    int okM = 0;
    int abM = 0;
    int i;
    logic [31:0] rng;
    logic [31:0] rd;
    logic err;
    logic [1:0] op;

    qdc_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclkPin(sclk), .frameSelectNPin(selN), .dataInPin(din), .chanCode(chanCode),
        .shutdown(shutdown), .termSel(termSel));
    qdc_serial_host i_host (.clk_sys(clk_sys), .sclk(sclk), .selN(selN), .din(din));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fails = fails + 1;
            complete_run();
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // answer is read right after the edge, before registered outputs move on
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic checkAll();
        int k;
        for (k = 0; k < NUM_CH; k++)
        begin
            chk("chanCode", {22'h0, chanCode[k]}, outM[k]);
            apb(1'b0, ADDR_CODE0 + 8'(4 * k), 32'h0);
            chk("code", rd, outM[k]);
            apb(1'b0, ADDR_HOLD0 + 8'(4 * k), 32'h0);
            chk("hold", rd, holdM[k]);
        end
        chk("shutdown", {31'h0, shutdown}, pdM);
        chk("termSel", {30'h0, termSel}, termM);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rd, {27'h0, 1'b0, okM != 0, termM[1:0], pdM[0]});
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("count", rd, {abM[15:0], okM[15:0]});
    endtask

    task automatic frame(input logic [1:0] a, input logic [1:0] o, input logic [11:0] d, input int edges);
        int k;
        i_host.sendFrame({a, o, d}, edges);
        repeat (4) @(posedge clk_sys);
        if (enM == 1 && edges < 16)
            abM++;
        if (enM == 1 && edges >= 16)
        begin
            okM++;
            pdM = (o == OP_POWER_DOWN);
            termM = (o != OP_POWER_DOWN) ? 0 : (a == 2'h1) ? 1 : (a == 2'h2) ? 2 : 0;
            for (k = 0; k < NUM_CH; k++)
            begin
                if (o == OP_WRITE_ALL || (o != OP_POWER_DOWN && k == a))
                    holdM[k] = d[11:2];
                if (o == OP_WRITE_ALL || o == OP_WRITE_UPDATE)
                    outM[k] = holdM[k];
            end
        end
        checkAll();
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rng = 32'h07067B94;
        for (i = 0; i < NUM_CH; i++)
        begin
            holdM[i] = 0;
            outM[i] = 0;
        end
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        checkAll();
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rd, CTRL_RESET);
        apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
        chk("slverr", {31'h0, err}, 32'h1);
        $display("test reset done");
        frame(2'h2, OP_WRITE_HOLD, 12'hFFF, 16);
        frame(2'h1, OP_WRITE_UPDATE, 12'h803, 16);
        frame(2'h3, OP_WRITE_ALL, 12'h555, 16);
        frame(2'h0, OP_WRITE_UPDATE, 12'h3FC, 15);
        frame(2'h0, OP_WRITE_ALL, 12'h3FC, 0);
        frame(2'h2, OP_WRITE_UPDATE, 12'h00C, 20);
        $display("test write and abort done");
        for (i = 0; i < 6; i++)
        begin
            rng = xorshift(rng);
            op = (rng[17:16] == 2'h3) ? OP_WRITE_UPDATE : rng[17:16];
            frame(rng[13:12], op, rng[11:0], 16);
        end
        $display("test random frames done");
        for (i = 0; i < 4; i++)
        begin
            rng = xorshift(rng);
            frame(2'(i), OP_POWER_DOWN, rng[11:0], 16);
            i_host.parkLow();
            // raising the parked select ends an empty frame, counted as aborted
            abM++;
            frame(2'(i + 1), OP_WRITE_HOLD, rng[27:16], 16);
        end
        $display("test power-down done");
        resetn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (i = 0; i < NUM_CH; i++)
        begin
            holdM[i] = 0;
            outM[i] = 0;
        end
        pdM = 0;
        termM = 0;
        okM = 0;
        abM = 0;
        resetn <= 1'b1;
        @(posedge clk_sys);
        checkAll();
        frame(2'h3, OP_WRITE_UPDATE, 12'h7F0, 16);
        $display("test mid-run reset done");
        apb(1'b1, ADDR_CTRL, 32'h0);
        enM = 0;
        frame(2'h1, OP_WRITE_ALL, 12'hABC, 16);
        apb(1'b1, ADDR_CTRL, 32'h1);
        enM = 1;
        frame(2'h1, OP_WRITE_ALL, 12'hABC, 16);
        $display("test enable done");
        complete_run();
    end
endmodule
